// [hw/uccs_pkg.sv]
// Purpose: Shared constants and types of the serial port control block
// Assumes: 8-bit special-function bus, control register on page zero
// Notes:   Bit positions follow the control register layout
package uccs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] UCCS_PAGE = 4'h0;
    localparam logic [7:0] UCCS_CTRL_ADDR = 8'h98;
    localparam logic [7:0] UCCS_DATA_ADDR = 8'h99;
    localparam logic [7:0] UCCS_CTRL_RESET = 8'h40;
    localparam logic [7:0] UCCS_ZERO_BYTE = 8'h00;
    localparam logic [4:0] UCCS_CTRL_BITBASE = 5'h13; // 0x98 >> 3

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int UCCS_B_MODE = 7;
    localparam int UCCS_B_ONE = 6;
    localparam int UCCS_B_FILT = 5;
    localparam int UCCS_B_REN = 4;
    localparam int UCCS_B_TB8 = 3;
    localparam int UCCS_B_RB8 = 2;
    localparam int UCCS_B_TI = 1;
    localparam int UCCS_B_RI = 0;

    // ----------------------------------------------------------------
    // Frame timing
    // ----------------------------------------------------------------
    localparam logic [3:0] UCCS_LAST_DATA = 4'h7;
    localparam logic [3:0] UCCS_CNT_ZERO = 4'h0;
    localparam logic [3:0] UCCS_CNT_ONE = 4'h1;
    localparam logic [7:0] UCCS_SHIFT_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Frame state machines
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        UCCS_IDLE,
        UCCS_START,
        UCCS_DATA,
        UCCS_NINTH,
        UCCS_STOP
    } uccs_frame_t;

endpackage : uccs_pkg

// [hw/uccs_rx.sv]
// Purpose: Receive framer: start detect, bit sampling, frame end pulse
// Assumes: ovf_i is one pulse per half bit time, rx_i synchronous
// Notes:   Start resets the bit phase so reception follows the line
`timescale 1ns/10ps
`default_nettype none

module uccs_rx
    import uccs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Control
    input wire logic enable_i,
    input wire logic nine_i,
    input wire logic ovf_i,
    // Serial line
    input wire logic rx_i,
    // Frame result
    output logic done_o,
    output logic [7:0] data_o,
    output logic bit9_o
);

    typedef struct packed {
        uccs_frame_t st;
        logic half;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic ninth;
        logic stop;
        logic done;
        logic prev;
    } uccs_rx_s_t;

    uccs_rx_s_t s;
    uccs_rx_s_t next_s;

    // Frame sequencing
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.prev = rx_i;
        case (s.st)
            UCCS_IDLE: begin
                if (enable_i && s.prev && !rx_i) begin
                    next_s.st = UCCS_START;
                    next_s.half = 1'b0;
                    next_s.cnt = UCCS_CNT_ZERO;
                end
            end
            UCCS_START: begin
                // Middle of start bit after one half bit
                if (ovf_i) begin
                    next_s.st = rx_i ? UCCS_IDLE : UCCS_DATA;
                end
            end
            UCCS_DATA: begin
                if (ovf_i) begin
                    next_s.half = ~s.half;
                    if (s.half) begin
                        next_s.shift = {rx_i, s.shift[7:1]};
                        next_s.cnt = s.cnt + UCCS_CNT_ONE;
                        if (s.cnt == UCCS_LAST_DATA) begin
                            next_s.st = nine_i ? UCCS_NINTH : UCCS_STOP;
                        end
                    end
                end
            end
            UCCS_NINTH: begin
                if (ovf_i) begin
                    next_s.half = ~s.half;
                    if (s.half) begin
                        next_s.ninth = rx_i;
                        next_s.st = UCCS_STOP;
                    end
                end
            end
            UCCS_STOP: begin
                if (ovf_i) begin
                    next_s.half = ~s.half;
                    if (s.half) begin
                        next_s.stop = rx_i;
                        next_s.done = 1'b1;
                        next_s.st = UCCS_IDLE;
                    end
                end
            end
            default: begin
                next_s.st = UCCS_IDLE;
            end
        endcase
        // Disabled receiver drops any frame in progress
        if (!enable_i) begin
            next_s.st = UCCS_IDLE;
            next_s.done = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s <= '{st: UCCS_IDLE, half: 1'b0, cnt: UCCS_CNT_ZERO,
                   shift: UCCS_SHIFT_ZERO, ninth: 1'b0, stop: 1'b0,
                   done: 1'b0, prev: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // Outputs
    assign done_o = s.done;
    assign data_o = s.shift;
    assign bit9_o = nine_i ? s.ninth : s.stop;

endmodule : uccs_rx

`default_nettype wire

// [hw/uccs_ctrl.sv]
// Purpose: Serial port control register, transmitter and flag logic
// Assumes: ovf_i is the baud timer overflow, two per bit time
// Notes:   Byte and single-bit access both reach the control register
//          Bit 6 is not stored; it reads one from the register view
//          Data buffer writes while a frame is being sent are dropped
`timescale 1ns/10ps
`default_nettype none

module uccs_ctrl
    import uccs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Special-function byte bus
    input wire logic [3:0] sfr_page_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // Special-function single-bit access
    input wire logic [7:0] bit_addr_i,
    input wire logic bit_wr_i,
    input wire logic bit_rd_i,
    input wire logic bit_wdata_i,
    output logic bit_rdata_o,
    // Baud timing and interrupt enable
    input wire logic ovf_i,
    input wire logic int_enable_i,
    output logic irq_o,
    // Serial lines
    input wire logic rx_i,
    output logic tx_o,
    output logic tx_busy_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        // Software fields of the control register
        logic mode;
        logic filt;
        logic ren;
        logic tb8;
        logic rb8;
        // Done flags, set by hardware, cleared by software
        logic ti;
        logic ri;
        // Receive buffer and registered read data
        logic [7:0] rbuf;
        logic [7:0] rdata;
        logic bdata;
        // Transmitter sequencing and line
        uccs_frame_t tst;
        logic thalf;
        logic [3:0] tcnt;
        logic [7:0] tshift;
        logic tline;
    } uccs_ctrl_s_t;

    uccs_ctrl_s_t s;
    uccs_ctrl_s_t next_s;

    // Receive framer results
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_bit9;

    // Decoded accesses
    logic page_ok;
    logic ctrl_wr;
    logic data_wr;
    logic bit_hit;

    // Register views and frame acceptance
    logic [7:0] ctrl_view;
    logic [7:0] ctrl_wval;
    logic accept;

    // ----------------------------------------------------------------
    // Receive framer
    // ----------------------------------------------------------------
    // Framer follows the stored mode and enable; clearing the enable
    // drops a frame in progress, so no half frame is delivered later
    uccs_rx u_rx (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(s.ren),
        .nine_i(s.mode),
        .ovf_i(ovf_i),
        .rx_i(rx_i),
        .done_o(rx_done),
        .data_o(rx_data),
        .bit9_o(rx_bit9)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Block answers only on its own page
    assign page_ok = (sfr_page_i == UCCS_PAGE);
    assign ctrl_wr = sfr_wr_i && page_ok && (sfr_addr_i == UCCS_CTRL_ADDR);
    assign data_wr = sfr_wr_i && page_ok && (sfr_addr_i == UCCS_DATA_ADDR);
    assign bit_hit = page_ok && (bit_addr_i[7:3] == UCCS_CTRL_BITBASE);

    // Read view of control register, bit 6 fixed high
    always_comb begin
        ctrl_view = {s.mode, 1'b1, s.filt, s.ren,
                     s.tb8, s.rb8, s.ti, s.ri};
    end

    // Value that a byte or single-bit write leaves in the register
    // Byte write wins over a single-bit write in the same cycle
    always_comb begin
        ctrl_wval = ctrl_view;
        if (ctrl_wr) begin
            ctrl_wval = sfr_wdata_i;
        end else if (bit_wr_i && bit_hit) begin
            ctrl_wval[bit_addr_i[2:0]] = bit_wdata_i;
        end
    end

    // Frame acceptance: flag free and filter satisfied
    // Flag still set means overrun: byte and ninth bit are dropped
    assign accept = !s.ri && (!s.filt || rx_bit9);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Software writes; bit 6 is never stored
        next_s.mode = ctrl_wval[UCCS_B_MODE];
        next_s.filt = ctrl_wval[UCCS_B_FILT];
        next_s.ren = ctrl_wval[UCCS_B_REN];
        next_s.tb8 = ctrl_wval[UCCS_B_TB8];
        next_s.rb8 = ctrl_wval[UCCS_B_RB8];
        next_s.ti = ctrl_wval[UCCS_B_TI];
        next_s.ri = ctrl_wval[UCCS_B_RI];

        // Accepted frame loads data and ninth bit, sets flag over clear
        if (rx_done && accept) begin
            next_s.rbuf = rx_data;
            next_s.rb8 = rx_bit9;
            next_s.ri = 1'b1;
        end

        // Registered read data; other pages and addresses read zero
        // Data stays until the next read strobe
        if (sfr_rd_i && page_ok && sfr_addr_i == UCCS_CTRL_ADDR) begin
            next_s.rdata = ctrl_view;
        end else if (sfr_rd_i && page_ok && sfr_addr_i == UCCS_DATA_ADDR) begin
            next_s.rdata = s.rbuf;
        end else if (sfr_rd_i) begin
            next_s.rdata = UCCS_ZERO_BYTE;
        end
        // Single-bit read outside the register reads zero
        if (bit_rd_i) begin
            next_s.bdata = bit_hit && ctrl_view[bit_addr_i[2:0]];
        end

        // Transmitter; a write while busy is ignored
        // Each bit stands two timer pulses; thalf marks the first one.
        // The line is loaded one bit ahead from tshift[1], because the
        // shift of the current bit lands on the same edge.
        case (s.tst)
            // Idle line high, data write starts the start bit
            UCCS_IDLE: begin
                next_s.tline = 1'b1;
                if (data_wr) begin
                    next_s.tst = UCCS_START;
                    next_s.tshift = sfr_wdata_i;
                    next_s.tcnt = UCCS_CNT_ZERO;
                    next_s.thalf = 1'b0;
                    next_s.tline = 1'b0;
                end
            end

            // Second pulse ends the start bit, first data bit follows
            UCCS_START: begin
                if (ovf_i) begin
                    next_s.thalf = ~s.thalf;
                    if (s.thalf) begin
                        next_s.tst = UCCS_DATA;
                        next_s.tline = s.tshift[0];
                    end
                end
            end

            // Eight data bits, then ninth bit or stop bit
            UCCS_DATA: begin
                if (ovf_i) begin
                    next_s.thalf = ~s.thalf;
                    if (s.thalf) begin
                        next_s.tshift = {1'b0, s.tshift[7:1]};
                        next_s.tcnt = s.tcnt + UCCS_CNT_ONE;
                        if (s.tcnt == UCCS_LAST_DATA) begin
                            if (s.mode) begin
                                next_s.tst = UCCS_NINTH;
                                next_s.tline = s.tb8;
                            end else begin
                                next_s.tst = UCCS_STOP;
                                next_s.tline = 1'b1;
                                next_s.ti = 1'b1;
                            end
                        end else begin
                            next_s.tline = s.tshift[1];
                        end
                    end
                end
            end

            // Ninth bit, flag set as the stop bit begins
            UCCS_NINTH: begin
                if (ovf_i) begin
                    next_s.thalf = ~s.thalf;
                    if (s.thalf) begin
                        next_s.tst = UCCS_STOP;
                        next_s.tline = 1'b1;
                        next_s.ti = 1'b1;
                    end
                end
            end

            // Stop bit stands its full time before the next frame
            UCCS_STOP: begin
                if (ovf_i) begin
                    next_s.thalf = ~s.thalf;
                    if (s.thalf) begin
                        next_s.tst = UCCS_IDLE;
                    end
                end
            end

            // Unused codes fall back to an idle line
            default: begin
                next_s.tst = UCCS_IDLE;
                next_s.tline = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset; fields come from the control reset value
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s <= '{mode: UCCS_CTRL_RESET[UCCS_B_MODE],
                   filt: UCCS_CTRL_RESET[UCCS_B_FILT],
                   ren: UCCS_CTRL_RESET[UCCS_B_REN],
                   tb8: UCCS_CTRL_RESET[UCCS_B_TB8],
                   rb8: UCCS_CTRL_RESET[UCCS_B_RB8],
                   ti: UCCS_CTRL_RESET[UCCS_B_TI],
                   ri: UCCS_CTRL_RESET[UCCS_B_RI],
                   rbuf: UCCS_ZERO_BYTE,
                   rdata: UCCS_ZERO_BYTE,
                   bdata: 1'b0,
                   tst: UCCS_IDLE,
                   thalf: 1'b0,
                   tcnt: UCCS_CNT_ZERO,
                   tshift: UCCS_SHIFT_ZERO,
                   tline: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfr_rdata_o = s.rdata;
    assign bit_rdata_o = s.bdata;
    assign tx_o = s.tline;
    assign tx_busy_o = (s.tst != UCCS_IDLE);
    // Request follows the flags at once; a software clear drops it
    // on the edge after the write, never earlier
    assign irq_o = int_enable_i && (s.ti || s.ri);

endmodule : uccs_ctrl

`default_nettype wire

// [tb/uccs_assertions.sv]
// Purpose: Port-level assertions for the serial port control block
// Assumes: Bound to uccs_ctrl, one clock domain
// Notes:   Flags are internal, so they are judged through irq_o
`timescale 1ns/10ps
`default_nettype none

module uccs_assertions
    import uccs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register access
    input wire logic [3:0] sfr_page_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] bit_addr_i,
    input wire logic bit_wr_i,
    input wire logic bit_rd_i,
    input wire logic bit_rdata_o,
    // Timing, interrupt and line
    input wire logic ovf_i,
    input wire logic int_enable_i,
    input wire logic irq_o,
    input wire logic tx_o,
    input wire logic tx_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // ----------------------------------------------------------------
    // Register side
    // ----------------------------------------------------------------
    logic pg0;
    assign pg0 = (sfr_page_i == UCCS_PAGE);

    byte_six_a: assert property (sfr_rd_i && pg0 &&
        sfr_addr_i == UCCS_CTRL_ADDR |=> sfr_rdata_o[6])
        else $error("fixed bit read as zero");
    bit_six_a: assert property (bit_rd_i && pg0 &&
        bit_addr_i == 8'h9e |=> bit_rdata_o)
        else $error("fixed bit single read as zero");
    page_miss_a: assert property (sfr_rd_i && !pg0
        |=> sfr_rdata_o == 8'h00) else $error("other page answered");
    rd_hold_a: assert property (!sfr_rd_i
        |=> $stable(sfr_rdata_o)) else $error("read data moved");
    irq_gate_a: assert property (!int_enable_i |-> !irq_o)
        else $error("request while disabled");
    flag_keep_a: assert property (irq_o && !sfr_wr_i && !bit_wr_i
        ##1 int_enable_i |-> irq_o) else $error("flag cleared by hardware");

    // ----------------------------------------------------------------
    // Transmit line
    // ----------------------------------------------------------------
    tx_start_a: assert property (sfr_wr_i && pg0 &&
        sfr_addr_i == UCCS_DATA_ADDR && !tx_busy_o |=> !tx_o && tx_busy_o)
        else $error("frame did not start");
    tx_idle_a: assert property (!tx_busy_o |-> tx_o)
        else $error("idle line low");
    tx_pace_a: assert property (!ovf_i && !sfr_wr_i
        |=> $stable(tx_o)) else $error("line moved off bit timer");

    cover property (irq_o);
    cover property ($rose(tx_busy_o));
    cover property (bit_rd_i && pg0 && bit_addr_i == 8'h9e);

endmodule : uccs_assertions

bind uccs_ctrl uccs_assertions chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .sfr_page_i(sfr_page_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o), .bit_addr_i(bit_addr_i),
    .bit_wr_i(bit_wr_i), .bit_rd_i(bit_rd_i), .bit_rdata_o(bit_rdata_o),
    .ovf_i(ovf_i), .int_enable_i(int_enable_i), .irq_o(irq_o),
    .tx_o(tx_o), .tx_busy_o(tx_busy_o)
);

`default_nettype wire

// [tb/uccs_node.sv]
// Purpose: Remote serial node on the transmit and receive lines
// Assumes: Two ovf_i pulses per bit time, line idles high
// Notes:   probe_i is sampled mid ninth slot to time the done flag
`timescale 1ns/10ps
`default_nettype none

module uccs_node (
    // Clock and bit timing
    input wire logic clk_i,
    input wire logic ovf_i,
    // Serial lines and probe
    input wire logic tx_i,
    input wire logic probe_i,
    output logic rx_o
);
    logic [8:0] got;
    logic got_probe;
    int n_frames;

    // Waits for n bit timer pulses
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            while (ovf_i !== 1'b1) @(posedge clk_i);
        end
    endtask : tick

    // Start, data LSB first, optional ninth bit, stop
    task automatic send(input logic [7:0] d, input logic nine,
                        input logic b9, input logic stop);
        logic [10:0] fr;
        fr = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        tick(1);
        for (int k = 0; k < (nine ? 11 : 10); k++) begin
            @(negedge clk_i);
            rx_o = fr[k];
            tick(2);
        end
        @(negedge clk_i);
        rx_o = 1'b1;
    endtask : send

    // Decodes each frame at mid bit, ninth slot is ninth or stop
    initial begin
        rx_o = 1'b1;
        n_frames = 0;
        forever begin
            @(negedge tx_i);
            tick(1);
            for (int k = 0; k < 9; k++) begin
                tick(2);
                got[k] = tx_i;
            end
            got_probe = probe_i;
            n_frames++;
        end
    end

endmodule : uccs_node

`default_nettype wire

// [tb/uccs_ctrl_tb.sv]
// Purpose: Self-checking bench for the serial port control block
// Assumes: Bit timer pulse every fourth clock, page zero by default
// Notes:   Remote node model drives rx and decodes tx
`timescale 1ns/10ps
`default_nettype none

module uccs_ctrl_tb import uccs_pkg::*;;
    logic clk, rstn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wd, ovf, int_en;
    logic rx, tx, busy, irq, brdata, m, f, b, acc;
    logic [1:0] div;
    logic [3:0] page;
    logic [7:0] addr, baddr, wdata, rdata, got, d, exp_buf;
    int fails, n_checks, seed, i, k, t;

    uccs_ctrl dut (
        .clk_i(clk), .rstn_i(rstn), .sfr_page_i(page),
        .sfr_addr_i(addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .bit_addr_i(baddr),
        .bit_wr_i(bit_wr), .bit_rd_i(bit_rd), .bit_wdata_i(bit_wd),
        .bit_rdata_o(brdata), .ovf_i(ovf), .int_enable_i(int_en),
        .irq_o(irq), .rx_i(rx), .tx_o(tx), .tx_busy_o(busy)
    );
    uccs_node node (
        .clk_i(clk), .ovf_i(ovf), .tx_i(tx), .probe_i(irq), .rx_o(rx)
    );

    // Clock and bit timer
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        div <= div + 2'h1;
        ovf <= (div == 2'h3);
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One access: 0 write, 1 read, 2 bit write, 3 bit read
    task automatic bus(input int op, input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        baddr = a;
        wdata = v;
        bit_wd = v[0];
        {sfr_wr, sfr_rd, bit_wr, bit_rd} = 4'h8 >> op;
        @(negedge clk);
        {sfr_wr, sfr_rd, bit_wr, bit_rd} = 4'h0;
        got = (op == 3) ? {7'h00, brdata} : rdata;
    endtask : bus

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Watchdog, well beyond the expected run
    initial begin
        #2000000;
        fails++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {rstn, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wd, ovf, int_en} = 8'h00;
        {div, page, addr, baddr, wdata} = 30'h0;
        {seed, fails, n_checks} = {32'd81, 64'd0};
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        bus(1, UCCS_CTRL_ADDR, 8'h00);
        check(got, 8'h40);
        // Random control values and interrupt gating
        for (i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            int_en = d[6];
            bus(0, UCCS_CTRL_ADDR, d);
            bus(1, UCCS_CTRL_ADDR, 8'h00);
            check(got, d | 8'h40);
            check({7'h00, irq}, {7'h00, d[6] & (d[1] | d[0])});
        end
        // Other page, unmapped address, single-bit access
        bus(0, UCCS_CTRL_ADDR, 8'h00);
        page = 4'h1;
        bus(0, UCCS_CTRL_ADDR, 8'h10);
        bus(1, UCCS_CTRL_ADDR, 8'h00);
        check(got, 8'h00);
        page = 4'h0;
        bus(1, 8'h9a, 8'h00);
        check(got, 8'h00);
        bus(2, 8'h9c, 8'h01);
        bus(2, 8'h9e, 8'h00);
        bus(1, UCCS_CTRL_ADDR, 8'h00);
        check(got, 8'h50);
        bus(3, 8'h9e, 8'h00);
        check(got, 8'h01);
        // Transmit in both modes, second write while busy
        int_en = 1'b1;
        for (i = 0; i < 4; i++) begin
            m = i[0];
            b = i[1];
            d = 8'($random(seed));
            bus(0, UCCS_CTRL_ADDR, {m, 3'h0, b, 3'h0});
            k = node.n_frames;
            bus(0, UCCS_DATA_ADDR, d);
            bus(0, UCCS_DATA_ADDR, ~d);
            for (t = 0; t < 500 && node.n_frames == k; t++) @(negedge clk);
            check(node.got[7:0], d);
            check({7'h00, node.got[8]}, {7'h00, m ? b : 1'b1});
            check({7'h00, node.got_probe}, {7'h00, !m});
            repeat (12) @(negedge clk);
            check({7'h00, busy}, 8'h00);
            check({7'h00, irq}, 8'h01);
            bus(2, 8'h99, 8'h00);
            check({7'h00, irq}, 8'h00);
        end
        // Mid-run reset restores the defaults and an idle line
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check({6'h00, busy, tx}, 8'h01);
        check({7'h00, irq}, 8'h00);
        bus(1, UCCS_CTRL_ADDR, 8'h00);
        check(got, 8'h40);
        // Receive filter table, disabled receiver, flag already set
        exp_buf = 8'h00;
        for (i = 0; i < 10; i++) begin
            m = i[0];
            f = i[1];
            b = i[2];
            d = 8'($random(seed));
            bus(0, UCCS_CTRL_ADDR, {m, 1'b0, f, i != 8, 3'h0, i == 9});
            node.send(d, m, b, m | b);
            acc = (i < 8) && (!f || b);
            if (acc) exp_buf = d;
            bus(1, UCCS_CTRL_ADDR, 8'h00);
            check(got, {m, 2'b11 & {1'b1, f}, i != 8, 1'b0, acc & b, 1'b0,
                        acc | (i == 9)});
            bus(1, UCCS_DATA_ADDR, 8'h00);
            check(got, exp_buf);
        end
        conclude();
    end

endmodule : uccs_ctrl_tb

`default_nettype wire
